// >>> hw/usb_ep_ctrl.v
// USB device endpoint control and status registers behind an APB slave.
// Assumes a transaction engine on the same clock that reports token events and
// link state; bus pins are synchronised here before use.
//
// Summary of operation
// - Writing one to soft reset resets the controller; hold ten system cycles.
// - Isochronous endpoints exchange data without any handshake unless stalled, which answers STALL.
// - Stall bit makes the endpoint answer any host data exchange with STALL.
// - Reply PID bit: zero answers DATA1, one answers DATA0.
// - Armed bit marks endpoint ready; hardware clears it when the exchange ends.
// - Endpoint enable bit; a disabled endpoint does not operate.
// - After OUT, status bit 7 holds the toggle of the last packet received.
// - Status bit 6 set on host ACK; bits 5..0 stall, NAK, timeout, overflow, setup, CRC.
// - Armed endpoint records transaction type: SETUP 00, IN 01, OUT 10.
// - Separate field records type of last transaction counted as NAK, unarmed isochronous ones included.
// - Link-state bit 2: zero means bus supply present, one absent.
// - Link field: 00 reset or detached, 01 low speed, 10 full speed.
// - Flag 5 set when bus supply appears; write one clears.
// - Flag 4 set whenever an endpoint counts a NAK, unarmed isochronous ones included; write one clears.
// - Flag 3 set on start-of-frame reception; write one clears.
// - Flag 2 set when both data lines are low; write one clears.
// - Flag 1 set when bus activity resumes; write one clears.
// - Flag 0 set on transaction completion; write one clears, zero no effect.
// - Device address is zero after reset until assigned.
`include "usb_ep_ctrl_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module usb_ep_ctrl #(
   parameter NUM_EP = 4
) (
   input wire clock_i,
   input wire rst_n_i,
   // APB slave
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   // Transaction engine reports (same clock)
   input wire tok_valid_i,
   input wire [1:0] tok_ep_i,
   input wire [1:0] tok_kind_i,
   input wire tok_toggle_i,
   input wire tok_host_ack_i,
   input wire [3:0] tok_err_i,
   input wire sof_i,
   input wire resume_i,
   input wire [1:0] line_speed_i,
   input wire [6:0] addr_i,
   input wire addr_load_i,
   // Pins from the transceiver (asynchronous)
   input wire dp_i,
   input wire dm_i,
   input wire vbus_absent_i,
   // Handshake decision for the engine, soft reset, pull-up control and interrupt
   output reg [1:0] reply_hs_o,
   output reg reply_data0_o,
   output reg ctrl_reset_o,
   output reg pullup_control_o,
   output reg irq_o
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   reg [2:0] pin_s1_q;
   reg [2:0] pin_s2_q;
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         // Idle J state, supply absent: no false SE0 or supply edge after reset
         pin_s1_q <= 3'h5;
         pin_s2_q <= 3'h5;
      end else begin
         pin_s1_q <= {vbus_absent_i, dm_i, dp_i};
         pin_s2_q <= pin_s1_q;
      end
   end
   wire vbus_absent_s = pin_s2_q[2];
   wire se0_s = ~pin_s2_q[0] & ~pin_s2_q[1];

   // ----------------------------------------------------------------
   // Soft reset: held for ten cycles after the write
   // ----------------------------------------------------------------
   reg [3:0] rst_cnt_q;
   wire wr_en = psel_i & penable_i & pwrite_i & ~pready_o;
   wire rd_en = psel_i & penable_i & ~pwrite_i & ~pready_o;
   wire soft_wr = wr_en & (paddr_i == `OFF_RESET_CTRL) & pwdata_i[`SOFT_RESET_BIT];
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         rst_cnt_q <= 4'h0;
         ctrl_reset_o <= 1'b0;
      end else begin
         if (soft_wr)
            rst_cnt_q <= `RESET_HOLD_CYCLES;
         else if (rst_cnt_q != 4'h0)
            rst_cnt_q <= rst_cnt_q - 4'h1;
         ctrl_reset_o <= soft_wr | (rst_cnt_q > 4'h1);
      end
   end
   // Internal state is cleared while the soft reset runs
   wire clr = ~rst_n_i | soft_wr | (rst_cnt_q != 4'h0);

   // ----------------------------------------------------------------
   // Endpoint registers
   // ----------------------------------------------------------------
   reg [4:0] ep_ctrl_q [0:NUM_EP-1];
   reg [7:0] ep_stat_q [0:NUM_EP-1];
   reg [1:0] ep_kind_q [0:NUM_EP-1];
   reg [1:0] ep_nak_kind_q [0:NUM_EP-1];
   wire [NUM_EP-1:0] ep_nak_now;
   wire [NUM_EP-1:0] ep_done_now;
   genvar g;
   generate
      for (g = 0; g < NUM_EP; g = g + 1) begin : g_ep
         wire [7:0] base = `OFF_EP_CTRL0 + g[7:0] * `EP_STRIDE;
         wire hit = tok_valid_i & (tok_ep_i == g[1:0]);
         wire en = ep_ctrl_q[g][`EPC_EN];
         wire armed = ep_ctrl_q[g][`EPC_ARMED];
         // Unarmed but enabled, non-stalled endpoint counts as NAK, isochronous ones included
         assign ep_nak_now[g] = hit & en & ~armed & ~ep_ctrl_q[g][`EPC_STALL];
         assign ep_done_now[g] = hit & en & armed & ~ep_ctrl_q[g][`EPC_STALL];
         always @(posedge clock_i) begin
            if (clr) begin
               ep_ctrl_q[g] <= 5'h00;
               ep_stat_q[g] <= 8'h00;
               ep_kind_q[g] <= `KIND_SETUP;
               ep_nak_kind_q[g] <= `KIND_SETUP;
            end else begin
               if (wr_en & (paddr_i == base))
                  ep_ctrl_q[g] <= pwdata_i[4:0];
               if (hit & en) begin
                  if (ep_done_now[g]) begin
                     ep_ctrl_q[g][`EPC_ARMED] <= 1'b0;
                     ep_kind_q[g] <= tok_kind_i;
                  end
                  if (ep_nak_now[g])
                     ep_nak_kind_q[g] <= tok_kind_i;
                  if (tok_kind_i == `KIND_OUT)
                     ep_stat_q[g][`EPS_TOGGLE] <= tok_toggle_i;
                  ep_stat_q[g][`EPS_ACK] <= tok_host_ack_i & ~ep_ctrl_q[g][`EPC_ISO];
                  ep_stat_q[g][`EPS_STALL] <= ep_ctrl_q[g][`EPC_STALL];
                  ep_stat_q[g][`EPS_NAK] <= ep_nak_now[g];
                  ep_stat_q[g][`EPS_TIMEOUT] <= tok_err_i[3];
                  ep_stat_q[g][`EPS_OVERFLOW] <= tok_err_i[2];
                  ep_stat_q[g][`EPS_SETUP] <= (tok_kind_i == `KIND_SETUP);
                  ep_stat_q[g][`EPS_CRC] <= tok_err_i[0];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Handshake decision for the addressed endpoint
   // ----------------------------------------------------------------
   always @(posedge clock_i) begin
      if (clr) begin
         reply_hs_o <= `HS_NONE;
         reply_data0_o <= 1'b0;
      end else if (tok_valid_i) begin
         reply_data0_o <= ep_ctrl_q[tok_ep_i][`EPC_PID];
         if (!ep_ctrl_q[tok_ep_i][`EPC_EN])
            reply_hs_o <= `HS_NONE;
         else if (ep_ctrl_q[tok_ep_i][`EPC_STALL])
            reply_hs_o <= `HS_STALL;
         else if (ep_ctrl_q[tok_ep_i][`EPC_ISO])
            reply_hs_o <= `HS_NONE;
         else if (!ep_ctrl_q[tok_ep_i][`EPC_ARMED])
            reply_hs_o <= `HS_NAK;
         else
            reply_hs_o <= `HS_ACK;
      end
   end

   // ----------------------------------------------------------------
   // Bus control, link state, address, events
   // ----------------------------------------------------------------
   reg [6:0] bus_ctrl_q;
   reg [6:0] addr_q;
   reg [5:0] flags_q;
   reg [5:0] mask_q;
   reg vbus_absent_q;
   reg se0_q;
   wire [5:0] ev_set;
   assign ev_set[`EV_SUPPLY] = vbus_absent_q & ~vbus_absent_s;
   assign ev_set[`EV_NAK] = |ep_nak_now;
   assign ev_set[`EV_SOF] = sof_i;
   assign ev_set[`EV_BUS_RESET] = se0_s & ~se0_q;
   assign ev_set[`EV_RESUME] = resume_i;
   assign ev_set[`EV_DONE] = |ep_done_now;
   wire flag_wr = wr_en & (paddr_i == `OFF_EVENT_FLAGS);
   always @(posedge clock_i) begin
      if (clr) begin
         bus_ctrl_q <= 7'h00;
         addr_q <= 7'h00;
         flags_q <= 6'h00;
         mask_q <= 6'h00;
         vbus_absent_q <= 1'b1;
         se0_q <= 1'b0;
         irq_o <= 1'b0;
         pullup_control_o <= 1'b0;
      end else begin
         vbus_absent_q <= vbus_absent_s;
         se0_q <= se0_s;
         if (wr_en & (paddr_i == `OFF_BUS_CTRL))
            bus_ctrl_q <= pwdata_i[6:0];
         if (wr_en & (paddr_i == `OFF_EVENT_MASK))
            mask_q <= pwdata_i[5:0];
         if (addr_load_i)
            addr_q <= addr_i;
         // Set wins over a simultaneous write-one clear
         flags_q <= (flags_q & ~({6{flag_wr}} & pwdata_i[5:0])) | ev_set;
         irq_o <= |(flags_q & mask_q);
         pullup_control_o <= bus_ctrl_q[6];
      end
   end

   // ----------------------------------------------------------------
   // APB read and answer: one wait state, ready in the access phase
   // ----------------------------------------------------------------
   reg [31:0] rd_d;
   reg hit_d;
   integer i;
   always @* begin
      rd_d = 32'h0000_0000;
      hit_d = 1'b0;
      case (paddr_i)
         `OFF_RESET_CTRL: begin
            hit_d = 1'b1;
            rd_d[`SOFT_RESET_BIT] = (rst_cnt_q != 4'h0);
         end
         `OFF_BUS_CTRL: begin
            hit_d = 1'b1;
            rd_d[6:0] = bus_ctrl_q;
         end
         `OFF_LINK_STATE: begin
            hit_d = 1'b1;
            rd_d[`LNK_VBUS] = vbus_absent_s;
            rd_d[1:0] = se0_s ? `LINE_RESET : line_speed_i;
         end
         `OFF_EVENT_FLAGS: begin
            hit_d = 1'b1;
            rd_d[5:0] = flags_q;
         end
         `OFF_EVENT_MASK: begin
            hit_d = 1'b1;
            rd_d[5:0] = mask_q;
         end
         `OFF_ADDR: begin
            hit_d = 1'b1;
            rd_d[6:0] = addr_q;
         end
         default: begin
            for (i = 0; i < NUM_EP; i = i + 1) begin
               if (paddr_i == `OFF_EP_CTRL0 + i[7:0] * `EP_STRIDE) begin
                  hit_d = 1'b1;
                  rd_d[4:0] = ep_ctrl_q[i];
               end
               if (paddr_i == `OFF_EP_STATUS0 + i[7:0] * `EP_STRIDE) begin
                  hit_d = 1'b1;
                  rd_d[7:0] = ep_stat_q[i];
               end
               if (paddr_i == `OFF_EP_KIND0 + i[7:0] * `EP_STRIDE) begin
                  hit_d = 1'b1;
                  rd_d[1:0] = ep_kind_q[i];
               end
               if (paddr_i == `OFF_EP_NAK_KIND0 + i[7:0] * `EP_STRIDE) begin
                  hit_d = 1'b1;
                  rd_d[1:0] = ep_nak_kind_q[i];
               end
            end
         end
      endcase
   end
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end else begin
         pready_o <= psel_i & penable_i & ~pready_o;
         pslverr_o <= psel_i & penable_i & ~pready_o & ~hit_d;
         prdata_o <= (rd_en & hit_d) ? rd_d : 32'h0000_0000;
      end
   end
endmodule // usb_ep_ctrl
`default_nettype wire

// >>> hw/usb_ep_ctrl_defines.vh
// Constants for the USB device endpoint control block.
// Included by the block's design file and the testbench; holds definitions alone.
`ifndef USB_EP_CTRL_DEFINES_VH
`define USB_EP_CTRL_DEFINES_VH
// Register byte offsets
`define OFF_RESET_CTRL 8'h00
`define OFF_EP_CTRL0 8'h08
`define OFF_EP_STATUS0 8'h0C
`define OFF_EP_KIND0 8'h10
`define OFF_EP_NAK_KIND0 8'h14
`define EP_STRIDE 8'h10
`define OFF_BUS_CTRL 8'h48
`define OFF_LINK_STATE 8'h4C
`define OFF_EVENT_FLAGS 8'h50
`define OFF_EVENT_MASK 8'h54
`define OFF_ADDR 8'h58
// Field positions
`define SOFT_RESET_BIT 1
`define EPC_ISO 4
`define EPC_STALL 3
`define EPC_PID 2
`define EPC_ARMED 1
`define EPC_EN 0
`define EPS_TOGGLE 7
`define EPS_ACK 6
`define EPS_STALL 5
`define EPS_NAK 4
`define EPS_TIMEOUT 3
`define EPS_OVERFLOW 2
`define EPS_SETUP 1
`define EPS_CRC 0
`define LNK_VBUS 2
`define EV_SUPPLY 5
`define EV_NAK 4
`define EV_SOF 3
`define EV_BUS_RESET 2
`define EV_RESUME 1
`define EV_DONE 0
// Encodings and reset values
`define KIND_SETUP 2'h0
`define KIND_IN 2'h1
`define KIND_OUT 2'h2
`define LINE_RESET 2'h0
`define LINE_LOW 2'h1
`define LINE_FULL 2'h2
`define RESET_HOLD_CYCLES 4'hA
`define HS_ACK 2'h0
`define HS_NAK 2'h1
`define HS_STALL 2'h2
`define HS_NONE 2'h3
`endif

// >>> test/testbench.sv
// Self-checking bench: APB master, read-result queue and monitor.
// Assumes the far-side model supplies tokens, events and pin levels.
`timescale 1ns/1ns
`default_nettype none
`include "usb_ep_ctrl_defines.vh"
module testbench;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
   note_t notes[$];
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic hack = 1'b1;
   logic [6:0] addr_v = 7'h00;
   logic addr_ld = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, reply_data0, ctrl_reset, irq, tv, tt, sof, res, dp, dm, vb;
   wire [1:0] reply_hs, tep, tkd, spd;
   int n_mismatch = 0;
   int tests_run = 0;
   logic [31:0] mode_ctrl [6] = '{32'h07, 32'h03, 32'h09, 32'h01, 32'h13, 32'h00};
   logic [1:0] mode_hs [6] = '{`HS_ACK, `HS_ACK, `HS_STALL, `HS_NAK, `HS_NONE, `HS_NONE};
   always #50 clock_i = ~clock_i;
   usb_ep_ctrl u_usb_ep_ctrl (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tok_valid_i(tv),
      .tok_ep_i(tep), .tok_kind_i(tkd), .tok_toggle_i(tt), .tok_host_ack_i(hack),
      .tok_err_i(4'h0), .sof_i(sof), .resume_i(res), .line_speed_i(spd), .addr_i(addr_v),
      .addr_load_i(addr_ld), .dp_i(dp), .dm_i(dm), .vbus_absent_i(vb), .reply_hs_o(reply_hs),
      .reply_data0_o(reply_data0), .ctrl_reset_o(ctrl_reset), .pullup_control_o(),
      .irq_o(irq));
   usb_host_model u_usb_host_model (.clock_i(clock_i), .tok_valid_o(tv), .tok_ep_o(tep),
      .tok_kind_o(tkd), .tok_toggle_o(tt), .sof_o(sof), .resume_o(res),
      .line_speed_o(spd), .dp_o(dp), .dm_o(dm), .vbus_absent_o(vb));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) chk("pready", 32'h0, 32'h1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
      input logic e = 1'b0);
      notes.push_back('{d, m, e});
      apb(1'b0, a, 32'h0);
   endtask
   // Monitor: each answered read consumes the oldest note
   always @(posedge clock_i) begin
      if (pready === 1'b1 && pwrite === 1'b0 && psel === 1'b1) begin
         chk("read data", prdata & notes[0].m, notes[0].d);
         chk("slave error", 32'(pslverr), 32'(notes[0].e));
         void'(notes.pop_front());
      end
   end
   task automatic test_done;
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clock_i);
      n_mismatch++;
      test_done();
   end
   initial begin
      logic [1:0] ep;
      logic [1:0] kd;
      logic tg;
      logic [7:0] base;
      void'($urandom(8810));
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(8'h50, 32'h0, 32'h3F);
      rd(8'h54, 32'h0, 32'h3F);
      rd(8'h14, 32'h0, 32'h3);
      rd(8'h58, 32'h0, 32'h7F);
      @(posedge clock_i);
      addr_v <= 7'h2A;
      addr_ld <= 1'b1;
      @(posedge clock_i);
      addr_ld <= 1'b0;
      rd(8'h58, 32'h2A, 32'h7F);
      rd(8'hFC, 32'h0, 32'hFFFFFFFF, 1'b1);
      for (int i = 0; i < 6; i++) begin
         ep = 2'($urandom % 4);
         kd = 2'($urandom % 3);
         tg = 1'($urandom % 2);
         base = {2'b00, ep, 4'h8};
         hack <= 1'($urandom % 2);
         // Write the mode's enable, arm, PID, stall and iso bits as one write; no transmit data to load beforehand
         apb(1'b1, base, mode_ctrl[i]);
         u_usb_host_model.xfer(ep, kd, tg);
         @(negedge clock_i);
         chk("reply", 32'(reply_hs), 32'(mode_hs[i]));
         if (mode_hs[i] == `HS_ACK) begin
            chk("reply pid", 32'(reply_data0), 32'(mode_ctrl[i][2]));
            rd(base, mode_ctrl[i] & 32'h1D, 32'h1F);
            rd(base + 8'h08, 32'(kd), 32'h3);
            rd(base + 8'h04, {24'h0, tg, hack, 6'h00}, kd == `KIND_OUT ? 32'hC0 : 32'h40);
            apb(1'b1, 8'h50, 32'h0);
            rd(8'h50, 32'h1, 32'h1);
         end
         if (mode_hs[i] == `HS_NAK) begin
            rd(base + 8'h0C, 32'(kd), 32'h3);
            rd(8'h50, 32'h10, 32'h10);
         end
         apb(1'b1, 8'h50, 32'h3F);
         apb(1'b1, base, 32'h0);
      end
      apb(1'b1, 8'h54, 32'h01);
      apb(1'b1, 8'h08, 32'h03);
      u_usb_host_model.xfer(2'h0, `KIND_IN, 1'b0);
      repeat (2) @(negedge clock_i);
      chk("irq raised", 32'(irq), 32'h1);
      apb(1'b1, 8'h50, 32'h01);
      @(negedge clock_i);
      chk("irq cleared", 32'(irq), 32'h0);
      u_usb_host_model.ev(1'b1);
      u_usb_host_model.ev(1'b0);
      repeat (3) @(negedge clock_i);
      chk("irq masked", 32'(irq), 32'h0);
      for (int k = 1; k < 3; k++) begin
         u_usb_host_model.pins(2'(k), 1'b1, 1'b0, 1'b1);
         repeat (4) @(posedge clock_i);
         rd(8'h4C, 32'h4 | 32'(k), 32'h7);
      end
      u_usb_host_model.pins(2'h2, 1'b0, 1'b0, 1'b0);
      repeat (6) @(posedge clock_i);
      rd(8'h4C, 32'h0, 32'h7);
      u_usb_host_model.pins(2'h2, 1'b1, 1'b0, 1'b0);
      rd(8'h50, 32'h2E, 32'h2E);
      apb(1'b1, 8'h50, 32'h3F);
      rd(8'h50, 32'h0, 32'h3F);
      apb(1'b1, 8'h00, 32'h2);
      @(negedge clock_i);
      chk("soft reset", 32'(ctrl_reset), 32'h1);
      // The controller must not be touched while its reset is held
      repeat (11) @(posedge clock_i);
      rd(8'h54, 32'h0, 32'h3F);
      rd(8'h58, 32'h0, 32'h7F);
      test_done();
   end
endmodule // testbench
`default_nettype wire

// >>> test/usb_ep_ctrl_properties.sv
// Port-level assertions for the USB endpoint control block.
// Sees only the top-level ports; bound into every instance below.
`timescale 1ns/1ns
`default_nettype none
module usb_ep_ctrl_checker (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic tok_valid_i,
   input wire logic addr_load_i,
   input wire logic vbus_absent_i,
   input wire logic [1:0] reply_hs_o,
   input wire logic ctrl_reset_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   // Sticky history; never cleared by soft reset, so the checks stay conservative
   logic mask_set_q;
   logic addr_set_q;
   wire rd_ok = pready_o && !pwrite_i;
   always @(posedge clock_i) begin
      if (!rst_n_i) begin
         mask_set_q <= 1'b0;
         addr_set_q <= 1'b0;
      end else begin
         if (psel_i && penable_i && pwrite_i && paddr_i == 8'h54 && pwdata_i[5:0] != 6'h00)
            mask_set_q <= 1'b1;
         if (addr_load_i)
            addr_set_q <= 1'b1;
      end
   end
   apb_answer_a: assert property ($rose(penable_i) && psel_i |=> pready_o)
      else $error("no answer one cycle after access");
   ready_pulse_a: assert property (pready_o |=> !pready_o)
      else $error("ready held longer than one cycle");
   refuse_zero_a: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
      else $error("refused access returned data");
   soft_reset_a: assert property (psel_i && penable_i && pwrite_i && !pready_o && paddr_i == 8'h00
      && pwdata_i[1] |=> ##1 ctrl_reset_o [*8])
      else $error("soft reset too short");
   mask_irq_a: assert property (!mask_set_q |-> !irq_o)
      else $error("interrupt with all masks clear");
   addr_zero_a: assert property (rd_ok && paddr_i == 8'h58 && !addr_set_q |-> prdata_o == 32'h0)
      else $error("address not zero after reset");
   vbus_read_a: assert property (rd_ok && paddr_i == 8'h4C && vbus_absent_i == $past(vbus_absent_i, 6)
      |-> prdata_o[2] == vbus_absent_i)
      else $error("supply bit wrong");
   reply_cause_a: assert property (!$stable(reply_hs_o) && !ctrl_reset_o && !$past(ctrl_reset_o)
      |-> $past(tok_valid_i))
      else $error("reply changed without token");
   cover property (ctrl_reset_o);
   cover property (pready_o && pslverr_o);
   cover property (irq_o);
endmodule // usb_ep_ctrl_checker
bind usb_ep_ctrl usb_ep_ctrl_checker u_checker (.clock_i, .rst_n_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tok_valid_i,
   .addr_load_i, .vbus_absent_i, .reply_hs_o, .ctrl_reset_o, .irq_o);
`default_nettype wire

// >>> test/usb_host_model.sv
// Far-side model: transaction engine reports and transceiver pins.
// Runs on the block's clock; token qualifiers are scrambled outside a report.
`timescale 1ns/1ns
`default_nettype none
module usb_host_model (
   input wire logic clock_i,
   output logic tok_valid_o = 1'b0,
   output logic [1:0] tok_ep_o = 2'h0,
   output logic [1:0] tok_kind_o = 2'h3,
   output logic tok_toggle_o = 1'b0,
   output logic sof_o = 1'b0,
   output logic resume_o = 1'b0,
   output logic [1:0] line_speed_o = 2'h2,
   output logic dp_o = 1'b1,
   output logic dm_o = 1'b0,
   output logic vbus_absent_o = 1'b1
);
   task automatic xfer(input logic [1:0] ep, input logic [1:0] kind, input logic tog);
      @(posedge clock_i);
      tok_valid_o <= 1'b1;
      tok_ep_o <= ep;
      tok_kind_o <= kind;
      tok_toggle_o <= tog;
      @(posedge clock_i);
      tok_valid_o <= 1'b0;
      tok_ep_o <= ~ep;
      tok_kind_o <= ~kind;
      tok_toggle_o <= ~tog;
   endtask
   task automatic ev(input logic is_sof);
      @(posedge clock_i);
      sof_o <= is_sof;
      resume_o <= !is_sof;
      @(posedge clock_i);
      sof_o <= 1'b0;
      resume_o <= 1'b0;
   endtask
   task automatic pins(input logic [1:0] spd, input logic p, input logic m, input logic vb);
      @(posedge clock_i);
      line_speed_o <= spd;
      dp_o <= p;
      dm_o <= m;
      vbus_absent_o <= vb;
   endtask
endmodule // usb_host_model
`default_nettype wire
